// file: hdl/pvsp_map.vh
// Register map, field positions, reset values and timing constants of the PCM voice slot port
`ifndef PVSP_MAP_VH
`define PVSP_MAP_VH
// Word offsets, one 32-bit register per address
`define PVSP_CTRL_OFS 4'h0
`define PVSP_FMT_OFS 4'h1
`define PVSP_SLOT_OFS 4'h2
`define PVSP_DIV_OFS 4'h3
`define PVSP_STAT_OFS 4'h4
`define PVSP_TX0_OFS 4'h5
`define PVSP_RX0_OFS 4'h8
// Control fields
`define PVSP_CTRL_EN 0
`define PVSP_CTRL_MASTER 1
`define PVSP_CTRL_LONG 2
`define PVSP_CTRL_BURST 3
`define PVSP_CTRL_MODE_LO 4
`define PVSP_CTRL_SLOTS_LO 6
// Format fields
`define PVSP_FMT_SHIFT_LO 0
`define PVSP_FMT_LSB_FIRST 2
`define PVSP_FMT_FILL_LO 3
`define PVSP_FMT_PROG_LO 5
// Reset values
`define PVSP_CTRL_RST 32'h0000_0000
`define PVSP_FMT_RST 32'h0000_0000
`define PVSP_SLOT_RST 32'h0000_0210
`define PVSP_DIV_RST 32'h0000_0030
// Fill codes
`define PVSP_FILL_ZERO 2'h0
`define PVSP_FILL_ONE 2'h1
`define PVSP_FILL_SIGN 2'h2
`define PVSP_FILL_PROG 2'h3
// Modes
`define PVSP_MODE_NB 2'h0
`define PVSP_MODE_WBS 2'h1
`define PVSP_MODE_SBC 2'h2
// Timing
`define PVSP_WORD_BITS 16
`define PVSP_SAMPLE_BITS 13
`define PVSP_LONG_SYNC_BITS 3
`define PVSP_CHANNELS 3
`endif

// file: hdl/pvsp_port.v
// PCM voice slot port: three time-slotted full-duplex channels with Avalon-MM register access
// Functional notes
// - Master drives bit clock and sync; slave takes both as inputs.
// - Up to three full-duplex channels share the port by time slots.
// - Each sample interval holds at most sixteen slots.
// - Slot count 1, 2, 4, 8 or 16 follows the chosen bus rate.
// - A channel sends and receives in the same slot.
// - Data output is released during slots no active channel owns.
// - Output released after falling edge in the slot's last bit.
// - Short or long sync selectable in master and slave roles.
// - Short sync is one bit period high, aligned to rising edge.
// - Slave short sync seen on falling edge; next rising starts slot zero.
// - Long sync is three bit periods high, starting with slot zero bit zero.
// - Narrowband uses 13 of 16 bits, position and order configurable.
// - Spare bits ignored on receive; filled zero, one, sign or programmed when left justified.
// - Reset format is 13-bit two's complement, left justified, MSB first.
// - Wideband transparent typically master, 4 kHz sync, 16-bit words.
// - Wideband transparent also works as slave.
// - SBC-code mode moves linear 16-bit samples at 16 kHz.
// - Burst mode allows a bit clock up to 24 MHz.
// - Burst mode is receive only, with short or long sync.
// - Two ports share pins with the I2S ports, one function at a time.
`timescale 1ns/10ps
`include "pvsp_map.vh"
module pvsp_port #(
   parameter CHANNELS = `PVSP_CHANNELS,
   parameter WORD_BITS = `PVSP_WORD_BITS
) (
   // System
   input wire core_clk,
   input wire reset_n,
   // Avalon-MM slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // PCM bit clock
   input wire pcm_clk_in,
   output reg pcm_clk_out,
   output reg pcm_clk_oe,
   // PCM frame sync
   input wire pcm_sync_in,
   output reg pcm_sync_out,
   output reg pcm_sync_oe,
   // PCM data
   input wire pcm_data_in,
   output reg pcm_data_out,
   output reg pcm_data_oe,
   // Pin sharing with the audio serial port
   output reg pcm_pins_owned
);

   // Registers
   reg [31:0] ctrl;
   reg [31:0] fmt;
   reg [31:0] slot_map;
   reg [31:0] div;
   reg [15:0] tx_word [0:2];
   reg [15:0] rx_word [0:2];
   reg [2:0] rx_new;
   reg ack;

   // Pin synchronisers
   reg [1:0] clk_meta;
   reg [1:0] sync_meta;
   reg [1:0] din_meta;
   reg clk_prev;

   // Bit engine
   reg [15:0] div_cnt;
   reg [3:0] bit_cnt;
   reg [3:0] slot_cnt;
   reg framed;
   reg sync_seen;
   reg [1:0] long_cnt;
   reg [15:0] tx_shift;
   reg [15:0] rx_shift;
   reg drive_slot;
   reg [1:0] own_ch;
   reg rel_pend;
   // Sync stays high for this many further rising edges after slot zero bit zero
   localparam [1:0] LONG_INIT = `PVSP_LONG_SYNC_BITS - 1;

   wire en = ctrl[`PVSP_CTRL_EN];
   wire master = ctrl[`PVSP_CTRL_MASTER];
   wire long_sync = ctrl[`PVSP_CTRL_LONG];
   wire burst = ctrl[`PVSP_CTRL_BURST];
   wire [1:0] mode = ctrl[`PVSP_CTRL_MODE_LO +: 2];
   wire [2:0] slots_log = ctrl[`PVSP_CTRL_SLOTS_LO +: 3];
   wire [1:0] fmt_shift = fmt[`PVSP_FMT_SHIFT_LO +: 2];
   wire lsb_first = fmt[`PVSP_FMT_LSB_FIRST];
   wire [1:0] fill = fmt[`PVSP_FMT_FILL_LO +: 2];
   wire [2:0] prog = fmt[`PVSP_FMT_PROG_LO +: 3];

   // Slot count as a power of two, capped at sixteen
   function [4:0] pvsp_slots;
      input [2:0] lg;
      begin
         pvsp_slots = (lg > 3'h4) ? 5'h10 : (5'h01 << lg);
      end
   endfunction

   // Channel owning a slot; 2'h3 means unused
   function [1:0] pvsp_owner;
      input [3:0] s;
      input [31:0] map;
      integer k;
      begin
         pvsp_owner = 2'h3;
         for (k = 2; k >= 0; k = k - 1) begin
            if (map[8 + k] && map[k * 4 +: 4] == s)
               pvsp_owner = k[1:0];
         end
      end
   endfunction

   // Transmit word formatting, 13-bit sample placed and padded
   function [15:0] pvsp_pack;
      input [15:0] w;
      input [1:0] md;
      input [1:0] sh;
      input [1:0] fl;
      input [2:0] pg;
      input lsbf;
      reg [15:0] r;
      reg [2:0] pad;
      begin
         r = w;
         pad = 3'h0;
         if (md == `PVSP_MODE_NB) begin
            case (fl)
               `PVSP_FILL_ZERO: pad = 3'h0;
               `PVSP_FILL_ONE: pad = 3'h7;
               `PVSP_FILL_SIGN: pad = {3{w[12]}};
               default: pad = pg;
            endcase
            r = {w[12:0], pad} >> (sh > 2'h3 ? 2'h3 : sh);
            r = r | ({pad, 13'h0000} >> (5'h10 - {3'h0, sh}));
         end
         // Order applied last so fill and shift keep their meaning
         if (lsbf)
            r = pvsp_rev(r);
         pvsp_pack = r;
      end
   endfunction

   // Receive word unpacking, spare bits dropped
   function [15:0] pvsp_unpack;
      input [15:0] w;
      input [1:0] md;
      input [1:0] sh;
      reg [15:0] t;
      begin
         t = w << sh;
         pvsp_unpack = (md == `PVSP_MODE_NB) ? {{3{t[15]}}, t[15:3]} : w;
      end
   endfunction

   // Bit order reversal
   function [15:0] pvsp_rev;
      input [15:0] w;
      integer k;
      begin
         for (k = 0; k < 16; k = k + 1)
            pvsp_rev[k] = w[15 - k];
      end
   endfunction

   // Synchronise pin inputs
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_meta <= 2'h0;
         sync_meta <= 2'h0;
         din_meta <= 2'h0;
         clk_prev <= 1'b0;
      end else begin
         clk_meta <= {clk_meta[0], pcm_clk_in};
         sync_meta <= {sync_meta[0], pcm_sync_in};
         din_meta <= {din_meta[0], pcm_data_in};
         clk_prev <= clk_meta[1];
      end
   end

   // Bit clock source: own divider as master, pin edges as slave
   wire div_done = (div_cnt == 16'h0000);
   wire m_rise = master && en && div_done && !pcm_clk_out;
   wire m_fall = master && en && div_done && pcm_clk_out;
   wire s_rise = !master && clk_meta[1] && !clk_prev;
   wire s_fall = !master && !clk_meta[1] && clk_prev;
   wire rise = en && (m_rise || s_rise);
   wire fall = en && (m_fall || s_fall);
   wire [4:0] nslots = pvsp_slots(slots_log);
   wire last_bit = (bit_cnt == 4'hf);
   wire last_slot = ({1'b0, slot_cnt} == nslots - 5'h01);
   wire [3:0] next_slot = last_bit ? (last_slot ? 4'h0 : slot_cnt + 4'h1) : slot_cnt;
   wire [1:0] next_own = pvsp_owner(last_bit && last_slot ? 4'h0 : next_slot, slot_map);
   wire frame_end = last_bit && last_slot;
   // Long sync slave starts on the rise that shows sync high; short sync waits for the flag
   wire slave_go = long_sync ? (sync_meta[1] && (!framed || frame_end)) : sync_seen;
   wire frame_go = master ? (!framed || frame_end) : slave_go;
   wire [1:0] first_own = pvsp_owner(4'h0, slot_map);
   wire [1:0] load_own = frame_go ? first_own : next_own;
   wire [1:0] load_idx = (load_own == 2'h3) ? 2'h0 : load_own;
   // Packed here so the first bit leaves on the same rise that loads the word
   wire [15:0] load_word = pvsp_pack(tx_word[load_idx], mode, fmt_shift, fill, prog, lsb_first);
   wire load_drive = !burst && load_own != 2'h3;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 16'h0000;
         pcm_clk_out <= 1'b0;
         pcm_clk_oe <= 1'b0;
         pcm_sync_out <= 1'b0;
         pcm_sync_oe <= 1'b0;
         pcm_data_out <= 1'b0;
         pcm_data_oe <= 1'b0;
         pcm_pins_owned <= 1'b0;
         bit_cnt <= 4'h0;
         slot_cnt <= 4'h0;
         framed <= 1'b0;
         sync_seen <= 1'b0;
         long_cnt <= 2'h0;
         tx_shift <= 16'h0000;
         rx_shift <= 16'h0000;
         drive_slot <= 1'b0;
         own_ch <= 2'h3;
         rel_pend <= 1'b0;
         rx_new <= 3'h0;
         rx_word[0] <= 16'h0000;
         rx_word[1] <= 16'h0000;
         rx_word[2] <= 16'h0000;
      end else begin
         pcm_pins_owned <= en;
         pcm_clk_oe <= en && master;
         pcm_sync_oe <= en && master;
         if (ack && avs_read && avs_address == `PVSP_STAT_OFS)
            rx_new <= 3'h0;
         if (!en) begin
            framed <= 1'b0;
            sync_seen <= 1'b0;
            pcm_clk_out <= 1'b0;
            pcm_sync_out <= 1'b0;
            pcm_data_oe <= 1'b0;
            div_cnt <= 16'h0000;
            rel_pend <= 1'b0;
         end else begin
            if (master)
               div_cnt <= div_done ? div[15:0] : div_cnt - 16'h0001;
            if (m_rise || m_fall)
               pcm_clk_out <= !pcm_clk_out;
            // Slave short sync sampled on falling edge; long sync is seen high at the rise instead
            if (fall && !master && !long_sync && sync_meta[1])
               sync_seen <= !framed || (last_bit && last_slot);
            // Release one core cycle after the last falling edge; a new owned slot still wins
            rel_pend <= fall && framed && last_bit;
            if (rel_pend)
               pcm_data_oe <= 1'b0;
            if (rise) begin
               sync_seen <= 1'b0;
               if (frame_go) begin
                  framed <= 1'b1;
                  bit_cnt <= 4'h0;
                  slot_cnt <= 4'h0;
                  own_ch <= load_own;
                  long_cnt <= LONG_INIT;
                  // Master sync: one bit short, three bits long, launched with slot zero
                  pcm_sync_out <= master;
               end else if (framed) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  slot_cnt <= next_slot;
                  if (long_cnt != 2'h0)
                     long_cnt <= long_cnt - 2'h1;
                  pcm_sync_out <= master && long_sync && long_cnt != 2'h0;
                  if (last_bit)
                     own_ch <= next_own;
               end
               // Launch on rising edge; a fresh word puts its first bit out at once
               if (frame_go || (framed && last_bit)) begin
                  tx_shift <= {load_word[14:0], 1'b0};
                  pcm_data_out <= load_word[15];
                  drive_slot <= load_drive;
                  pcm_data_oe <= load_drive;
               end else if (framed) begin
                  tx_shift <= {tx_shift[14:0], 1'b0};
                  pcm_data_out <= tx_shift[15];
                  pcm_data_oe <= drive_slot;
               end
            end
            // Capture on falling edge, same slot as transmit
            if (fall && framed && own_ch != 2'h3) begin
               rx_shift <= {rx_shift[14:0], din_meta[1]};
               if (last_bit) begin
                  rx_word[own_ch] <= pvsp_unpack(lsb_first ? pvsp_rev({rx_shift[14:0], din_meta[1]}) :
                     {rx_shift[14:0], din_meta[1]}, mode, fmt_shift);
                  rx_new[own_ch] <= 1'b1;
               end
            end
         end
      end
   end

   // Avalon-MM slave, one wait state per access
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= `PVSP_CTRL_RST;
         fmt <= `PVSP_FMT_RST;
         slot_map <= `PVSP_SLOT_RST;
         div <= `PVSP_DIV_RST;
         tx_word[0] <= 16'h0000;
         tx_word[1] <= 16'h0000;
         tx_word[2] <= 16'h0000;
         ack <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
         avs_waitrequest <= !((avs_read || avs_write) && !ack);
         if ((avs_read || avs_write) && !ack) begin
            avs_readdata <= 32'h0000_0000;
            if (avs_write) begin
               // Configuration comes only from software
               case (avs_address)
                  `PVSP_CTRL_OFS: ctrl <= {23'h0, avs_writedata[8:0]};
                  `PVSP_FMT_OFS: fmt <= {24'h0, avs_writedata[7:0]};
                  `PVSP_SLOT_OFS: slot_map <= {21'h0, avs_writedata[10:0]};
                  `PVSP_DIV_OFS: div <= {16'h0, avs_writedata[15:0]};
                  4'h5: tx_word[0] <= avs_writedata[15:0];
                  4'h6: tx_word[1] <= avs_writedata[15:0];
                  4'h7: tx_word[2] <= avs_writedata[15:0];
                  default: ;
               endcase
            end else begin
               case (avs_address)
                  `PVSP_CTRL_OFS: avs_readdata <= ctrl;
                  `PVSP_FMT_OFS: avs_readdata <= fmt;
                  `PVSP_SLOT_OFS: avs_readdata <= slot_map;
                  `PVSP_DIV_OFS: avs_readdata <= div;
                  `PVSP_STAT_OFS: avs_readdata <= {24'h0, slot_cnt, framed, rx_new};
                  4'h5: avs_readdata <= {16'h0, tx_word[0]};
                  4'h6: avs_readdata <= {16'h0, tx_word[1]};
                  4'h7: avs_readdata <= {16'h0, tx_word[2]};
                  4'h8: avs_readdata <= {16'h0, rx_word[0]};
                  4'h9: avs_readdata <= {16'h0, rx_word[1]};
                  4'ha: avs_readdata <= {16'h0, rx_word[2]};
                  default: avs_readdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

endmodule

// file: verif/pvsp_codec_model.sv
// Codec acting as PCM bus master: 32-bit frames, word in bits 0 to 15
`timescale 1ns/10ps
module pvsp_codec_model (
   // Control
   input wire run,
   input wire long_sync,
   input wire [15:0] tx_word,
   // Link
   output reg bclk,
   output reg sync,
   output reg din,
   input wire dout,
   input wire dout_oe,
   // Captured word
   output reg [15:0] rx_word
);
   integer b;
   initial begin
      bclk = 1'b0;
      sync = 1'b0;
      din = 1'b0;
      rx_word = 16'h0000;
      forever begin
         wait (run === 1'b1);
         for (b = 0; b < 32; b = b + 1) begin
            bclk = 1'b1;
            sync = long_sync ? (b < 3) : (b == 31);
            din = (b < 16) ? tx_word[15 - b] : ~din; // Idle line keeps moving
            #62.5;
            bclk = 1'b0;
            if (b < 16) rx_word[15 - b] = dout_oe ? dout : 1'bx;
            #62.5;
         end
         sync = 1'b0;
      end
   end
endmodule

// file: verif/pvsp_port_bench.sv
// Self-checking bench for the PCM voice slot port
`timescale 1ns/10ps
`include "pvsp_map.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pvsp_port_bench;
   typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e;} pvsp_row_t;
   reg core_clk, reset_n, avs_read, avs_write, p_run, p_long;
   reg [3:0] avs_address;
   reg [31:0] avs_writedata, q;
   reg [15:0] p_tx, w;
   wire [31:0] avs_readdata;
   wire [15:0] p_rx;
   wire avs_waitrequest, pcm_clk_out, pcm_clk_oe, pcm_sync_out, pcm_sync_oe, pcm_data_out, pcm_data_oe;
   wire pcm_pins_owned, p_bclk, p_sync, p_din, clk_pin, sync_pin;
   integer n_fail = 0, num_checks = 0, i, j, ns, noe, oe_seen = 0;
   pvsp_row_t rows [0:7];
   reg [15:0] fill_exp [0:3];
   // Shared pins resolve from whoever drives them
   assign clk_pin = pcm_clk_oe ? pcm_clk_out : p_bclk;
   assign sync_pin = pcm_sync_oe ? pcm_sync_out : p_sync;
   pvsp_port u_dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pcm_clk_in(clk_pin), .pcm_clk_out(pcm_clk_out),
      .pcm_clk_oe(pcm_clk_oe), .pcm_sync_in(sync_pin), .pcm_sync_out(pcm_sync_out), .pcm_sync_oe(pcm_sync_oe),
      .pcm_data_in(p_din), .pcm_data_out(pcm_data_out), .pcm_data_oe(pcm_data_oe),
      .pcm_pins_owned(pcm_pins_owned));
   pvsp_codec_model u_codec (.run(p_run), .long_sync(p_long), .tx_word(p_tx), .bclk(p_bclk), .sync(p_sync),
      .din(p_din), .dout(pcm_data_out), .dout_oe(pcm_data_oe), .rx_word(p_rx));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (pcm_data_oe === 1'b1) oe_seen = oe_seen + 1;
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_write <= wr;
         avs_read <= ~wr;
         @(posedge core_clk);
         while (avs_waitrequest !== 1'b0) @(posedge core_clk);
         q = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   // Master frame: word from slot 0, then driven bits in slot 1, sync bits over both slots
   task grab;
      begin
         ns = 0;
         noe = 0;
         while (pcm_sync_out !== 1'b0) @(posedge core_clk);
         while (pcm_sync_out !== 1'b1) @(posedge core_clk);
         for (j = 0; j < 32; j = j + 1) begin
            @(negedge pcm_clk_out);
            if (j < 16) w[15 - j] = pcm_data_oe ? pcm_data_out : 1'bx;
            else noe = noe + pcm_data_oe;
            ns = ns + pcm_sync_out;
         end
      end
   endtask
   task test_done;
      begin
         $display("Checks %0d, failures %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   initial begin
      #400000;
      n_fail = n_fail + 1;
      test_done;
   end
   initial begin
      rows[0] = {1'b0, `PVSP_CTRL_OFS, 32'h0, `PVSP_CTRL_RST};
      rows[1] = {1'b0, `PVSP_FMT_OFS, 32'h0, `PVSP_FMT_RST};
      rows[2] = {1'b0, `PVSP_SLOT_OFS, 32'h0, `PVSP_SLOT_RST};
      rows[3] = {1'b0, `PVSP_DIV_OFS, 32'h0, `PVSP_DIV_RST};
      rows[4] = {1'b0, 4'hf, 32'h0, 32'h0};
      rows[5] = {1'b1, 4'hf, 32'hffff_ffff, 32'h0};
      rows[6] = {1'b1, `PVSP_FMT_OFS, 32'hff, 32'hff};
      rows[7] = {1'b1, `PVSP_DIV_OFS, 32'h1, 32'h1};
      fill_exp[0] = 16'hd5e0;
      fill_exp[1] = 16'hd5e7;
      fill_exp[2] = 16'hd5e7;
      fill_exp[3] = 16'hd5e5;
      {reset_n, avs_read, avs_write, p_run, p_long} = 5'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      p_tx = 16'h0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 8; i = i + 1) begin
         if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0);
         `CHK(q, rows[i].e)
      end
      $display("Register table done");
      bus(1'b1, `PVSP_SLOT_OFS, 32'h100);
      bus(1'b1, `PVSP_TX0_OFS, 32'ha5c3);
      for (i = 0; i < 2; i = i + 1) begin
         bus(1'b1, `PVSP_CTRL_OFS, 32'h0);
         bus(1'b1, `PVSP_CTRL_OFS, 32'h53 | (i << 2));
         grab;
         `CHK(w, 16'hc3a5)
         `CHK(pcm_pins_owned, 1'b1)
         `CHK(pcm_sync_oe, 1'b1)
         `CHK(noe, 0)
         `CHK(ns, i ? 3 : 1)
         `CHK(pcm_clk_oe, 1'b1)
      end
      $display("Master frames done");
      bus(1'b1, `PVSP_TX0_OFS, 32'h1abc);
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, `PVSP_FMT_OFS, 32'ha0 | (i << 3));
         bus(1'b1, `PVSP_CTRL_OFS, 32'h43);
         grab;
         `CHK(w, fill_exp[i])
      end
      $display("Fill codes done");
      bus(1'b1, `PVSP_CTRL_OFS, 32'h0);
      bus(1'b1, `PVSP_FMT_OFS, 32'h0);
      // Slave runs: short sync, long sync, then burst receive only
      for (i = 0; i < 3; i = i + 1) begin
         p_long <= i[0];
         p_tx <= 16'h3c5a ^ i[15:0];
         bus(1'b1, `PVSP_TX0_OFS, 32'h5a3c ^ i);
         bus(1'b1, `PVSP_CTRL_OFS, 32'h51 | (i << 2));
         oe_seen = 0;
         p_run <= 1'b1;
         repeat (1300) @(posedge core_clk);
         p_run <= 1'b0;
         repeat (420) @(posedge core_clk);
         bus(1'b0, `PVSP_RX0_OFS, 32'h0);
         `CHK(q[15:0], 16'h3c5a ^ i[15:0])
         `CHK(pcm_clk_oe, 1'b0)
         if (i < 2) `CHK(p_rx, 16'h5a3c ^ i[15:0])
         else `CHK(oe_seen, 0)
      end
      $display("Slave frames done");
      test_done;
   end
endmodule

// file: verif/pvsp_port_sva.sv
// Assertion checker for the PCM voice slot port
`timescale 1ns/10ps
module pvsp_port_sva (
   // System
   input wire core_clk,
   input wire reset_n,
   // Bus
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   // Link
   input wire pcm_clk_out,
   input wire pcm_clk_oe,
   input wire pcm_sync_out,
   input wire pcm_sync_oe,
   input wire pcm_data_out,
   input wire pcm_data_oe,
   input wire pcm_pins_owned
);
   reg clk_q;
   reg [2:0] sync_bits;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Rising bit edges seen while sync is high; saturates so it cannot wrap
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_q <= 1'b0;
         sync_bits <= 3'h0;
      end else begin
         clk_q <= pcm_clk_out;
         if (!pcm_sync_out || !pcm_sync_oe) begin
            sync_bits <= 3'h0;
         end else if (pcm_clk_out && !clk_q && sync_bits != 3'h7) begin
            sync_bits <= sync_bits + 3'h1;
         end
      end
   end
   a_bus_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
      else $error("bus answer late");
   a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_bus_noreq: assert property (!avs_read && !avs_write && !$past(avs_read) && !$past(avs_write) |-> avs_waitrequest)
      else $error("answer without request");
   a_role_pair: assert property (pcm_clk_oe == pcm_sync_oe)
      else $error("clock and sync roles differ");
   a_pins_idle: assert property (!pcm_pins_owned |-> !pcm_clk_oe && !pcm_data_oe)
      else $error("pins driven while not owned");
   a_sync_width: assert property (sync_bits <= 3'h3)
      else $error("sync pulse too wide");
   a_sync_rise: assert property (pcm_sync_oe && $rose(pcm_sync_out) |-> pcm_clk_out)
      else $error("sync not on rising bit edge");
   a_data_launch: assert property (pcm_clk_oe && pcm_data_oe && $past(pcm_data_oe) && $changed(pcm_data_out)
      |-> pcm_clk_out)
      else $error("data changed in low phase");
   a_data_release: assert property (pcm_clk_oe && $fell(pcm_data_oe) |-> !pcm_clk_out || !$past(pcm_clk_out))
      else $error("data released before falling edge");
endmodule
bind pvsp_port pvsp_port_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pcm_clk_out(pcm_clk_out),
   .pcm_clk_oe(pcm_clk_oe), .pcm_sync_out(pcm_sync_out), .pcm_sync_oe(pcm_sync_oe),
   .pcm_data_out(pcm_data_out), .pcm_data_oe(pcm_data_oe), .pcm_pins_owned(pcm_pins_owned));
